// file: verilog/rxsc_pkg.sv
package rxsc_pkg;
  localparam int          RXSC_MAX_FRAME     = 1518;   // Frame too long threshold, bytes
  localparam int          RXSC_TYPE_LIMIT    = 1500;   // Length/type above this is a type
  localparam int          RXSC_TYPE_MIN_LEN  = 14;     // Runt limit for the type bit
  localparam int          RXSC_RUNT_LEN      = 64;     // Collision window, bytes
  localparam int          RXSC_WDOG_BYTES    = 2048;   // Watchdog limit, within 2048..2560
  localparam int          RXSC_DRIB_MII      = 4;      // Leftover bits reported in MII mode
  localparam int          RXSC_DRIB_10M      = 3;      // Least leftover bits in 10 Mbps mode
  localparam int          RXSC_LEN_W         = 14;
  localparam int          RXSC_ES_POS        = 15;
  localparam int          RXSC_RUNT_POS      = 11;
  localparam int          RXSC_LONG_POS      = 7;
  localparam int          RXSC_LATE_POS      = 6;
  localparam int          RXSC_TYPE_POS      = 5;
  localparam int          RXSC_WDOG_POS      = 4;
  localparam int          RXSC_MIIERR_POS    = 3;
  localparam int          RXSC_DRIB_POS      = 2;
  localparam int          RXSC_CRC_POS       = 1;
  localparam logic [15:0] RXSC_STATUS_RESET  = 16'h0000;

  // One received byte or the frame's end marker from the MAC receive path
  typedef struct packed {
    logic       byte_valid;   // Data byte present
    logic [7:0] data;         // Byte value
    logic       rx_er;        // Receive error seen with this beat
    logic       collision;    // Collision seen with this beat
    logic       frame_end;    // Last beat of the frame
    logic [2:0] extra_bits;   // Leftover bits after the last whole byte
    logic       crc_bad;      // Frame check sequence mismatch
  } rxsc_beat_t;

  typedef struct packed {
    logic [RXSC_LEN_W-1:0] length;   // Frame length, bytes
    logic [15:0]           status;   // Lower status half
  } rxsc_status_t;
endpackage : rxsc_pkg

// file: verilog/rxsc_skid.sv
`timescale 1ns/1ps
module rxsc_skid #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,    // System clock
  input  wire logic             reset,      // Synchronous reset, high
  input  wire logic             in_valid,   // Word offered
  output logic                  in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Offered word
  output logic                  out_valid,  // Word held
  input  wire logic             out_ready,  // Receiver takes the word
  output logic      [WIDTH-1:0] out_data    // Head word
);
  logic [WIDTH-1:0] mem [2];
  logic             rd_ptr;
  logic             wr_ptr;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : rxsc_skid

// file: verilog/rxsc_rx_status.sv
`timescale 1ns/1ps
// Operation
// - Status bits 9:8 and 0 always read zero.
// - Bit 7 set for frames over 1518 bytes; frame never truncated.
// - Bit 6 set on collision after the collision window.
// - Bit 5 set when length/type above 1500; never for frames under 14 bytes.
// - Bit 4 set when the frame runs past the watchdog byte limit.
// - Bit 3 set when RX_ER seen anywhere in the frame.
// - Bit 2 set for 4 leftover bits in MII, at least 3 at 10 Mbps.
// - Dribbling bit forced clear when late collision is flagged.
// - Bit 1 set on FCS mismatch or any RX_ER during the frame.
// - Host ignores CRC bit for runts, late collisions, watchdog expiry.
// - One stopped pulse once the receiver really halts after disable.
// - Receiver keeps running after the error flag rises.
// - Error flag on data underrun, status underrun or status overrun.
// - Bit 15 is the OR of bits 11, 7, 6 and 1.
module rxsc_rx_status
  import rxsc_pkg::*;
#(
  parameter int WDOG_BYTES = RXSC_WDOG_BYTES
) (
  input  wire logic                  sys_clk,                 // System clock, 200 MHz
  input  wire logic                  reset,                   // Synchronous reset, high
  input  wire rxsc_pkg::rxsc_beat_t  beat,                    // Receive beat from MII side
  output logic                       beat_ready,              // Beat accepted this cycle
  input  wire logic                  mode_10m,                // 10 Mbps operating mode
  input  wire logic                  receive_enable_bit,      // Receiver enable
  output logic                       receiver_stopped_pulse,  // One-cycle halt pulse
  output logic                       receiver_running,        // Receiver active
  output rxsc_pkg::rxsc_status_t     status_word,             // Head status word
  output logic                       status_valid,            // Status word available
  input  wire logic                  status_ready,            // Downstream takes word
  input  wire logic                  data_fifo_underrun,      // Host read empty data FIFO
  input  wire logic                  status_fifo_underrun,    // Host read empty status FIFO
  input  wire logic                  error_clear,             // Clear error flag
  output logic                       receiver_error_flag      // Sticky receiver error
);
  import rxsc_pkg::*;

  typedef enum logic [1:0] {RXSC_STOPPED, RXSC_IDLE, RXSC_FRAME, RXSC_DRAIN} rxsc_state_t;

  rxsc_state_t           state;
  rxsc_state_t           next_state;
  logic [RXSC_LEN_W-1:0] byte_count;
  logic [15:0]           type_field;
  logic                  late_col;
  logic                  mii_err;
  logic                  wdog;
  logic                  ovf_drop;
  logic                  frame_beat;
  logic                  push_valid;
  logic                  push_ready;
  rxsc_status_t          push_word;
  logic [RXSC_LEN_W-1:0] final_len;
  logic                  status_overrun;
  logic                  err_event;
  logic                  halting;

  // Beats are consumed as long as a frame is open, even if its status slot is full
  // A disabled idle receiver opens no new frame
  assign frame_beat = (state == RXSC_FRAME) ||
                      (state == RXSC_IDLE && receive_enable_bit && beat.byte_valid);
  assign beat_ready = frame_beat || state == RXSC_DRAIN;
  assign final_len  = byte_count + RXSC_LEN_W'(beat.byte_valid);

  always_comb begin
    next_state = state;
    case (state)
      RXSC_STOPPED: if (receive_enable_bit) next_state = RXSC_IDLE;
      RXSC_IDLE: begin
        if (!receive_enable_bit) next_state = RXSC_STOPPED;
        else if (beat.byte_valid && !beat.frame_end) next_state = RXSC_FRAME;
      end
      RXSC_FRAME: begin
        if (beat.frame_end) next_state = receive_enable_bit ? RXSC_IDLE : RXSC_STOPPED;
      end
      default: next_state = RXSC_STOPPED;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= RXSC_STOPPED;
    end else begin
      state <= next_state;
    end
  end

  // Pulse only on a real halt, never while a frame is open
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      receiver_stopped_pulse <= 1'b0;
    end else begin
      receiver_stopped_pulse <= halting;
    end
  end

  // Stop counts only once the open frame has closed
  assign halting          = (state != RXSC_STOPPED) && (next_state == RXSC_STOPPED);
  assign receiver_running = (state != RXSC_STOPPED);

  // Per-frame accumulation; counter saturates rather than truncating the frame
  // Collisions between frames go unseen; only frame beats are checked
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      byte_count <= '0;
      type_field <= 16'h0000;
      late_col   <= 1'b0;
      mii_err    <= 1'b0;
      wdog       <= 1'b0;
    end else if (frame_beat && beat.frame_end) begin
      byte_count <= '0;
      type_field <= 16'h0000;
      late_col   <= 1'b0;
      mii_err    <= 1'b0;
      wdog       <= 1'b0;
    end else if (frame_beat) begin
      if (beat.byte_valid && byte_count != '1) begin
        byte_count <= byte_count + RXSC_LEN_W'(1);
      end
      if (beat.byte_valid && byte_count == RXSC_LEN_W'(12)) begin
        type_field[15:8] <= beat.data;
      end
      if (beat.byte_valid && byte_count == RXSC_LEN_W'(13)) begin
        type_field[7:0] <= beat.data;
      end
      if (beat.collision && byte_count >= RXSC_LEN_W'(RXSC_RUNT_LEN)) begin
        late_col <= 1'b1;
      end
      if (beat.rx_er) begin
        mii_err <= 1'b1;
      end
      if (byte_count >= RXSC_LEN_W'(WDOG_BYTES)) begin
        wdog <= 1'b1;
      end
    end
  end

  // Status word assembled from the accumulated flags plus the final beat
  logic [15:0] st;
  logic        lc_now;
  logic        er_now;
  logic        drib;
  logic        type_now;
  logic [15:0] type_seen;
  logic        wdog_now;
  logic        runt_now;
  always_comb begin
    lc_now   = late_col ||
               (beat.collision && byte_count >= RXSC_LEN_W'(RXSC_RUNT_LEN));
    er_now   = mii_err || beat.rx_er;
    drib     = mode_10m ? (beat.extra_bits >= 3'(RXSC_DRIB_10M))
                        : (beat.extra_bits == 3'(RXSC_DRIB_MII));
    // Low type byte may still be on the bus in the closing beat
    type_seen = {type_field[15:8],
                 (byte_count == RXSC_LEN_W'(13)) ? beat.data : type_field[7:0]};
    type_now  = (final_len >= RXSC_LEN_W'(RXSC_TYPE_MIN_LEN)) &&
                (type_seen > 16'(RXSC_TYPE_LIMIT));
    wdog_now  = wdog || (final_len > RXSC_LEN_W'(WDOG_BYTES));
    runt_now  = final_len < RXSC_LEN_W'(RXSC_RUNT_LEN);
    st = RXSC_STATUS_RESET;
    st[RXSC_RUNT_POS]   = runt_now;
    st[RXSC_LONG_POS]   = final_len > RXSC_LEN_W'(RXSC_MAX_FRAME);
    st[RXSC_LATE_POS]   = lc_now;
    st[RXSC_TYPE_POS]   = type_now;
    st[RXSC_WDOG_POS]   = wdog_now;
    st[RXSC_MIIERR_POS] = er_now;
    st[RXSC_DRIB_POS]   = drib && !lc_now;
    st[RXSC_CRC_POS]    = beat.crc_bad || er_now;
    st[RXSC_ES_POS]     = st[RXSC_RUNT_POS] | st[RXSC_LONG_POS] |
                          st[RXSC_LATE_POS] | st[RXSC_CRC_POS];
  end

  assign push_valid     = frame_beat && beat.frame_end;
  assign push_word      = '{length: final_len, status: st};
  assign status_overrun = push_valid && !push_ready;
  // Either FIFO underrun or a status overrun; reception itself is never held off
  assign err_event      = data_fifo_underrun || status_fifo_underrun || ovf_drop;

  // Flagged a cycle after the lost push, keeping it off the ready path
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ovf_drop <= 1'b0;
    end else begin
      ovf_drop <= status_overrun;
    end
  end

  // Sticky; a new event in the clearing cycle wins. Reception is never blocked.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      receiver_error_flag <= 1'b0;
    end else if (err_event) begin
      receiver_error_flag <= 1'b1;
    end else if (error_clear) begin
      receiver_error_flag <= 1'b0;
    end
  end

  // Two slots let a finished word wait while the next frame streams in
  rxsc_skid #(
    .WIDTH ($bits(rxsc_status_t))
  ) u_status_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (status_valid),
    .out_ready (status_ready),
    .out_data  (status_word)
  );
endmodule : rxsc_rx_status

// file: verification/rxsc_rx_status_monitor.sv
`timescale 1ns/1ps
module rxsc_rx_status_monitor
  import rxsc_pkg::*;
#(
  parameter int WDOG_BYTES = RXSC_WDOG_BYTES
) (
  input wire logic                   sys_clk,                 // Clock
  input wire logic                   reset,                   // Sync reset
  input wire logic                   receiver_stopped_pulse,  // Halt pulse
  input wire logic                   receiver_running,        // Active
  input wire rxsc_pkg::rxsc_status_t status_word,             // Head word
  input wire logic                   status_valid,            // Word held
  input wire logic                   data_fifo_underrun,      // Data underrun
  input wire logic                   status_fifo_underrun,    // Status underrun
  input wire logic                   error_clear,             // Clear
  input wire logic                   receiver_error_flag      // Sticky error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire [15:0] st = status_word.status;
  sequence one_pulse_s;
    receiver_stopped_pulse ##1 !receiver_stopped_pulse;
  endsequence
  rsv_zero_a: assert property (status_valid |-> st[9:8] == 2'h0 && !st[0])
    else $error("reserved bits set");
  long_flag_a: assert property (status_valid |-> st[7] == (status_word.length > 14'h05EE))
    else $error("long flag wrong");
  wdog_len_a: assert property (status_valid && st[4] |-> status_word.length > WDOG_BYTES)
    else $error("watchdog flag early");
  drib_late_a: assert property (status_valid && st[6] |-> !st[2])
    else $error("dribble with late collision");
  err_sum_a: assert property (status_valid |-> st[15] == (st[11] | st[7] | st[6] | st[1]))
    else $error("summary bit wrong");
  stop_pulse_a: assert property ($fell(receiver_running) |-> one_pulse_s)
    else $error("stop pulse wrong");
  err_raise_a: assert property (data_fifo_underrun || status_fifo_underrun
    |-> ##[1:2] receiver_error_flag) else $error("error flag not raised");
  err_hold_a: assert property (receiver_error_flag && !error_clear |=> receiver_error_flag)
    else $error("error flag dropped");
endmodule : rxsc_rx_status_monitor

// file: verification/rxsc_host_model.sv
`timescale 1ns/1ps
module rxsc_host_model
  import rxsc_pkg::*;
(
  input  wire logic                   sys_clk,       // Clock
  input  wire logic                   reset,         // Sync reset
  input  wire logic                   stall,         // Hold off reads
  input  wire rxsc_pkg::rxsc_status_t status_word,   // Head word
  input  wire logic                   status_valid,  // Word held
  output logic                        status_ready,  // Pop request
  output logic                        got,           // Word taken
  output logic                        got_good,      // Taken word is a usable frame
  output rxsc_pkg::rxsc_status_t      got_word       // Taken word
);
  // Random reads stall the buffer now and then
  always_ff @(posedge sys_clk) begin
    status_ready <= !reset && !stall && ($urandom_range(0, 3) != 0);
    got <= status_valid && status_ready;
    got_word <= status_word;
    // Dribbling alone never spoils a frame; CRC is moot once runt, late or watchdog
    got_good <= status_valid && status_ready && !status_word.status[RXSC_CRC_POS] &&
                !(status_word.status[RXSC_RUNT_POS] | status_word.status[RXSC_LATE_POS] |
                  status_word.status[RXSC_WDOG_POS]);
  end
endmodule : rxsc_host_model

// file: verification/rxsc_rx_status_test.sv
`timescale 1ns/1ps
module rxsc_rx_status_test;
  import rxsc_pkg::*;
  logic sys_clk, reset, mode_10m, receive_enable_bit, stall, got, status_ready, beat_ready;
  logic data_fifo_underrun, status_fifo_underrun, error_clear, receiver_stopped_pulse;
  logic receiver_running, status_valid, receiver_error_flag, got_good;
  rxsc_beat_t   beat;
  rxsc_status_t status_word, got_word;
  int           fails, n_tests, pulses, ln;
  logic [29:0]  exp_q[$];
  logic [29:0]  e;
  rxsc_rx_status uut (.sys_clk, .reset, .beat, .beat_ready, .mode_10m, .receive_enable_bit,
    .receiver_stopped_pulse, .receiver_running, .status_word, .status_valid, .status_ready,
    .data_fifo_underrun, .status_fifo_underrun, .error_clear, .receiver_error_flag);
  rxsc_host_model host (.sys_clk, .reset, .stall, .status_word, .status_valid,
    .status_ready, .got, .got_good, .got_word);
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_tests++;
    if (a !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic drain;
    for (int k = 0; k < 300 && exp_q.size() > 0; k++) tick(1);
    tick(4);
    chk(exp_q.size(), 0);
  endtask : drain
  task automatic send(input int len, typ, col, er, cb, xb, stop);
    logic [15:0] s;
    s = 16'h0000;
    s[11] = len < 64;
    s[7] = len > 1518;
    s[6] = col >= 64;
    s[5] = len >= 14 && typ > 1500;
    s[4] = len > 2048;
    s[3] = er[0];
    s[2] = !s[6] && (mode_10m ? xb >= 3 : xb == 4);
    s[1] = cb[0] || er[0];
    s[15] = s[11] | s[7] | s[6] | s[1];
    exp_q.push_back({14'(len), s});
    for (int i = 0; i < len; i++) begin
      beat <= '{1'b1, (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : 8'($urandom),
        er[0] && i == len / 2, i == col, i == len - 1, (i == len - 1) ? 3'(xb) : 3'h0,
        cb[0] && i == len - 1};
      if (stop && i == len / 2) receive_enable_bit = 1'h0;
      if (stop && i == len - 1) chk(pulses, 0);
      tick(1);
    end
    beat <= '0;
    tick(1);
  endtask : send
  always @(posedge sys_clk) begin
    if (got === 1'h1) begin
      e = exp_q.size() ? exp_q.pop_front() : 30'h3FFFFFFF;
      chk({2'h0, got_word}, {2'h0, e});
      chk(got_good, !e[1] && !(e[11] | e[6] | e[4]));
    end
    if (beat.byte_valid === 1'h1) chk(beat_ready, 1'h1);
    if (receiver_stopped_pulse === 1'h1) pulses++;
  end
  initial begin
    #200000;
    fails++;
    test_done();
  end
  initial begin
    {reset, mode_10m, receive_enable_bit, stall, error_clear} = 5'h10;
    {data_fifo_underrun, status_fifo_underrun} = 2'h0;
    beat = '0;
    void'($urandom(32'h46D4));
    repeat (6) @(posedge sys_clk);
    #1 reset = 1'h0;
    receive_enable_bit = 1'h1;
    tick(1);
    send(1, 0, -1, 0, 0, 0, 0);
    send(13, 16'hFFFF, -1, 0, 0, 0, 0);
    send(14, 1501, -1, 0, 0, 0, 0);
    send(14, 1500, 2, 0, 0, 0, 0);
    send(1518, 16'h0800, -1, 0, 0, 0, 0);
    send(1519, 16'h0800, -1, 0, 1, 0, 0);
    send(2100, 16'h0800, -1, 0, 0, 0, 0);
    send(100, 64, 90, 0, 0, 4, 0);
    send(60, 64, -1, 1, 0, 0, 0);
    for (int m = 0; m < 6; m++) begin
      mode_10m = m[0];
      send(70, 16'h88B5, -1, 0, 0, 2 + m / 2, 0);
    end
    repeat (10) begin
      ln = $urandom_range(80, 1600);
      send(ln, $urandom_range(0, 16'hFFFF), $urandom_range(0, 1) ? ln - 1 : 5,
        $urandom_range(0, 1), $urandom_range(0, 1), $urandom_range(0, 4), 0);
    end
    drain();
    pulses = 0;
    send(40, 0, -1, 0, 0, 0, 1);
    tick(3);
    chk(pulses, 1);
    chk(receiver_running, 1'h0);
    drain();
    receive_enable_bit = 1'h1;
    tick(1);
    stall = 1'h1;
    drain();
    for (int f = 0; f < 3; f++) send(20, 0, -1, 0, 0, 0, 0);
    void'(exp_q.pop_back());
    tick(3);
    chk(receiver_error_flag, 1'h1);
    error_clear = 1'h1;
    tick(1);
    error_clear = 1'h0;
    tick(1);
    chk(receiver_error_flag, 1'h0);
    stall = 1'h0;
    for (int u = 0; u < 2; u++) begin
      {data_fifo_underrun, status_fifo_underrun} = u ? 2'h1 : 2'h2;
      tick(1);
      {data_fifo_underrun, status_fifo_underrun} = 2'h0;
      send(30, 0, -1, 0, 0, 0, 0);
      chk(receiver_error_flag, 1'h1);
      error_clear = 1'h1;
      tick(1);
      error_clear = 1'h0;
    end
    drain();
    {data_fifo_underrun, error_clear} = 2'h3;
    tick(1);
    {data_fifo_underrun, error_clear} = 2'h0;
    chk(receiver_error_flag, 1'h1);
    reset = 1'h1;
    tick(2);
    reset = 1'h0;
    chk(receiver_error_flag, 1'h0);
    chk(receiver_running, 1'h0);
    tick(1);
    send(64, 16'h0800, -1, 0, 0, 0, 0);
    drain();
    test_done();
  end
endmodule : rxsc_rx_status_test
bind rxsc_rx_status rxsc_rx_status_monitor #(.WDOG_BYTES(WDOG_BYTES)) mon (.sys_clk, .reset,
  .receiver_stopped_pulse, .receiver_running, .status_word, .status_valid,
  .data_fifo_underrun, .status_fifo_underrun, .error_clear, .receiver_error_flag);
